// >>> rtl/ess_exception_state_status.sv
// Exception state status registers with a classic Wishbone slave
//
// Local design decisions: the address map and register access over Wishbone.
`timescale 1ns/10ps
module ess_exception_state_status #(
  parameter int NUM_IRQ = 44
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire ess_pkg::ess_wb_req_t wbReq,
  output ess_pkg::ess_wb_rsp_t wbRsp,
  input wire logic [5:0] handlerExceptionNumber,
  input wire logic [63:0] activeMask,
  input wire logic [63:0] pendingMask,
  input wire logic [63:0] enableMask,
  input wire logic [511:0] priorityLevels,
  output logic [5:0] activeVectorNumber,
  output logic [5:0] pendingVectorNumber,
  output logic returnToBaseFlag,
  output logic [5:0] irqIndex,
  output logic irqIndexValid
);
  // Elaboration check of the interrupt count
  if (NUM_IRQ < 1 || NUM_IRQ > 44) begin : g_bad_num_irq
    $error("NUM_IRQ out of range");
  end

  function automatic logic isImpl(input logic [5:0] n);
    return (n <= ess_pkg::EXC_MAX) && (n < ess_pkg::EXC_IRQ0 + 6'(NUM_IRQ)
      || n < ess_pkg::EXC_IRQ0);
  endfunction

  function automatic logic isFaultOrNmi(input logic [5:0] n);
    return (n >= ess_pkg::EXC_NMI) && (n <= ess_pkg::EXC_USAGE);
  endfunction

  // Nmi and faults, service calls, tick and implemented external vectors from 0x10
  function automatic logic isEncoded(input logic [5:0] n);
    return isFaultOrNmi(n) || n == ess_pkg::EXC_SVC || n == ess_pkg::EXC_PENDSVC
      || n == ess_pkg::EXC_TICK || (n >= ess_pkg::EXC_IRQ0 && isImpl(n));
  endfunction

  logic [7:0] basePriorityMask;
  logic faultDisableMask;
  logic wbAck;
  logic [31:0] wbDat;

  // Active exceptions that count toward the flag
  logic [63:0] countedActive;
  always_comb begin
    countedActive = 64'h0;
    for (int i = 0; i < ess_pkg::NUM_EXC; i++) begin
      countedActive[i] = activeMask[i] && !isFaultOrNmi(6'(i)) && isEncoded(6'(i))
        && 6'(i) != handlerExceptionNumber;
    end
  end

  logic [6:0] otherActive;
  always_comb begin
    otherActive = 7'h00;
    for (int i = 0; i < ess_pkg::NUM_EXC; i++) begin
      if (countedActive[i]) begin
        otherActive = otherActive + 7'h01;
      end
    end
  end

  // Flag set when no other active exception apart from nmi and faults
  wire logic next_returnToBase = (otherActive == 7'h00);

  logic [5:0] bestNum;
  logic [7:0] bestPrio;
  logic bestFound;
  always_comb begin
    bestNum = ess_pkg::EXC_NONE;
    bestPrio = ess_pkg::PRIO_LOWEST;
    bestFound = 1'b0;
    for (int i = 0; i < ess_pkg::NUM_EXC; i++) begin
      // Fault mask blocks all but nmi; base priority gates by level
      if (pendingMask[i] && enableMask[i] && isEncoded(6'(i))
          && !(faultDisableMask && 6'(i) != ess_pkg::EXC_NMI)
          && (basePriorityMask == ess_pkg::BASE_PRIORITY_MASK_OFF || 6'(i) == ess_pkg::EXC_NMI
              || 6'(i) == ess_pkg::EXC_HARD
              || priorityLevels[i*8 +: 8] < basePriorityMask)
          && (!bestFound || priorityLevels[i*8 +: 8] < bestPrio)) begin
        bestNum = 6'(i);
        bestPrio = priorityLevels[i*8 +: 8];
        bestFound = 1'b1;
      end
    end
  end

  // Active vector mirrors the handler number when it is encoded, zero otherwise
  wire logic [5:0] next_active = isEncoded(handlerExceptionNumber)
    ? handlerExceptionNumber : ess_pkg::EXC_NONE;
  wire logic next_irqValid = (next_active >= ess_pkg::EXC_IRQ0);
  wire logic [5:0] next_irqIndex = next_irqValid
    ? 6'(next_active - ess_pkg::IRQ_OFFSET) : 6'h00;

  // Bus decode
  wire logic busReq = wbReq.cyc && wbReq.stb && !wbAck;
  wire logic busWrite = busReq && wbReq.we;
  wire logic hitPrio = wbReq.adr == ess_pkg::ADDR_PRIO;
  wire logic [31:0] stateWord = {14'h0000, pendingVectorNumber, returnToBaseFlag,
    5'h00, activeVectorNumber};
  wire logic [31:0] prioWord = {23'h000000, faultDisableMask, basePriorityMask};
  wire logic [31:0] idxWord = {25'h0000000, irqIndexValid, irqIndex};
  wire logic [31:0] next_wbDat = (wbReq.adr == ess_pkg::ADDR_STATE) ? stateWord
    : hitPrio ? prioWord
    : (wbReq.adr == ess_pkg::ADDR_IRQIDX) ? idxWord : 32'h00000000;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      basePriorityMask <= ess_pkg::PRIO_RESET;
      faultDisableMask <= 1'b0;
    end else if (busWrite && hitPrio) begin
      if (wbReq.sel[0]) begin
        basePriorityMask <= wbReq.dat[ess_pkg::PRIO_LSB +: 8];
      end
      if (wbReq.sel[1]) begin
        faultDisableMask <= wbReq.dat[ess_pkg::FAULT_DISABLE_MASK_BIT];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wbAck <= 1'b0;
      wbDat <= 32'h00000000;
    end else begin
      wbAck <= busReq;
      wbDat <= busReq ? next_wbDat : 32'h00000000;
    end
  end

  // Status registered from the live program status
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      activeVectorNumber <= ess_pkg::ACT_RESET;
      pendingVectorNumber <= ess_pkg::PEND_RESET;
      returnToBaseFlag <= ess_pkg::RET_RESET;
      irqIndex <= 6'h00;
      irqIndexValid <= 1'b0;
    end else begin
      // Thread mode reads zero via the mirror
      activeVectorNumber <= next_active;
      pendingVectorNumber <= bestNum;
      // Flag follows live state, meaningful in handlers only
      returnToBaseFlag <= next_returnToBase;
      irqIndex <= next_irqIndex;
      irqIndexValid <= next_irqValid;
    end
  end

  assign wbRsp.ack = wbAck;
  assign wbRsp.dat = wbDat;
endmodule

// >>> rtl/ess_pkg.sv
// Package of constants and carrier types for the exception state status block
package ess_pkg;
  localparam int EXC_W = 6;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 4;
  // Exception numbers
  localparam logic [5:0] EXC_NONE = 6'h00;
  localparam logic [5:0] EXC_NMI = 6'h02;
  localparam logic [5:0] EXC_HARD = 6'h03;
  localparam logic [5:0] EXC_MEM = 6'h04;
  localparam logic [5:0] EXC_BUS = 6'h05;
  localparam logic [5:0] EXC_USAGE = 6'h06;
  localparam logic [5:0] EXC_SVC = 6'h0b;
  localparam logic [5:0] EXC_PENDSVC = 6'h0e;
  localparam logic [5:0] EXC_TICK = 6'h0f;
  localparam logic [5:0] EXC_IRQ0 = 6'h10;
  localparam logic [5:0] EXC_MAX = 6'h3b;
  localparam logic [5:0] IRQ_OFFSET = 6'h10;
  localparam int NUM_EXC = 64;
  // Register map (byte addresses)
  localparam logic [3:0] ADDR_STATE = 4'h0;
  localparam logic [3:0] ADDR_PRIO = 4'h4;
  localparam logic [3:0] ADDR_IRQIDX = 4'h8;
  // Field positions of the state register
  localparam int ACT_LSB = 0;
  localparam int RET_BIT = 11;
  localparam int PEND_LSB = 12;
  // Reset values, priority constants and priority register fields
  localparam logic [5:0] ACT_RESET = 6'h00;
  localparam logic [5:0] PEND_RESET = 6'h00;
  localparam logic RET_RESET = 1'b0;
  localparam logic [7:0] PRIO_RESET = 8'h00;
  localparam logic [7:0] PRIO_LOWEST = 8'hff;
  localparam logic [7:0] BASE_PRIORITY_MASK_OFF = 8'h00;
  localparam int PRIO_LSB = 0;
  localparam int FAULT_DISABLE_MASK_BIT = 8;
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [3:0] adr;
    logic [31:0] dat;
  } ess_wb_req_t;
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } ess_wb_rsp_t;
endpackage

// >>> verification/ess_core_model.sv
// Core exception entry and return model
`timescale 1ns/10ps
module ess_core_model (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic enterReq,
  input wire logic leaveReq,
  input wire logic [5:0] enterVec,
  output logic [5:0] handler,
  output logic [63:0] actMask
);
  logic [5:0] stack [8];
  logic [2:0] depth;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      depth <= 3'h0;
      handler <= 6'h00;
      actMask <= 64'h0;
    end else if (enterReq) begin
      stack[depth] <= handler;
      depth <= depth + 3'h1;
      handler <= enterVec;
      actMask[enterVec] <= 1'b1;
    end else if (leaveReq && depth != 3'h0) begin
      actMask[handler] <= 1'b0;
      handler <= stack[depth - 3'h1];
      depth <= depth - 3'h1;
    end
  end
endmodule

// >>> verification/ess_status_asserts.sv
// Port assertions for the status block
`timescale 1ns/10ps
module ess_status_asserts #(
  parameter int NUM_IRQ = 44
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire ess_pkg::ess_wb_req_t wbReq,
  input wire ess_pkg::ess_wb_rsp_t wbRsp,
  input wire logic [5:0] handlerExceptionNumber,
  input wire logic [63:0] activeMask,
  input wire logic [5:0] activeVectorNumber,
  input wire logic [5:0] pendingVectorNumber,
  input wire logic returnToBaseFlag,
  input wire logic [5:0] irqIndex,
  input wire logic irqIndexValid
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire logic [63:0] others = activeMask & ~64'h7c & ~(64'h1 << handlerExceptionNumber);
  wire logic [5:0] hn = handlerExceptionNumber;
  act_mirror_a: assert property ((hn >= 6'h0e && hn <= 6'h3b) |=>
    activeVectorNumber == $past(hn)) else $error("active vector wrong");
  thread_zero_a: assert property (hn == 6'h00 |=> activeVectorNumber == 6'h00)
    else $error("thread active not zero");
  irq_index_a: assert property ((hn >= 6'h10 && hn <= 6'h3b) |=> irqIndexValid &&
    irqIndex == $past(hn) - 6'h10) else $error("irq index wrong");
  ret_base_a: assert property (rst_n |=> returnToBaseFlag == ($past(others) == 64'h0))
    else $error("return flag wrong");
  resv_zero_a: assert property (wbRsp.ack && $past(wbReq.adr) == ess_pkg::ADDR_STATE |->
    wbRsp.dat[10:6] == 5'h0) else $error("reserved bits set");
  ack_pulse_a: assert property (wbRsp.ack |=> !wbRsp.ack) else $error("ack too long");
  ack_prompt_a: assert property (wbReq.cyc && wbReq.stb && !wbRsp.ack |=> wbRsp.ack)
    else $error("ack late");
  pend_range_a: assert property (int'(pendingVectorNumber) < 16 + NUM_IRQ)
    else $error("pending reserved");
endmodule
bind ess_exception_state_status ess_status_asserts #(.NUM_IRQ(NUM_IRQ)) u_chk (
  .sys_clk(sys_clk), .rst_n(rst_n), .wbReq(wbReq), .wbRsp(wbRsp),
  .handlerExceptionNumber(handlerExceptionNumber), .activeMask(activeMask),
  .activeVectorNumber(activeVectorNumber), .pendingVectorNumber(pendingVectorNumber),
  .returnToBaseFlag(returnToBaseFlag), .irqIndex(irqIndex), .irqIndexValid(irqIndexValid));

// >>> verification/exception_state_status_tb.sv
// Testbench for the exception state status block
`timescale 1ns/10ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("ERROR %s exp %h got %h", n, e, g); end end
module exception_state_status_tb;
  logic sys_clk = 0, rst_n = 0, enterReq = 0, leaveReq = 0, retB, irqV;
  logic [5:0] enterVec = 0, hNum, actV, pendV, irqI;
  logic [63:0] actM, pendM = 0, enM = '1;
  logic [511:0] prio = 0;
  logic [31:0] rd;
  int bad_count = 0, total_checks = 0;
  ess_pkg::ess_wb_req_t wbReq = '0;
  ess_pkg::ess_wb_rsp_t wbRsp;
  always #5 sys_clk = ~sys_clk;
  ess_core_model u_core (.sys_clk(sys_clk), .rst_n(rst_n), .enterReq(enterReq),
    .leaveReq(leaveReq), .enterVec(enterVec), .handler(hNum), .actMask(actM));
  ess_exception_state_status u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .wbReq(wbReq),
    .wbRsp(wbRsp), .handlerExceptionNumber(hNum), .activeMask(actM), .pendingMask(pendM),
    .enableMask(enM), .priorityLevels(prio), .activeVectorNumber(actV),
    .pendingVectorNumber(pendV), .returnToBaseFlag(retB), .irqIndex(irqI),
    .irqIndexValid(irqV));
  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge sys_clk) wbReq <= '{1'b1, 1'b1, we, 4'hf, a, d};
    do @(posedge sys_clk) n++; while (wbRsp.ack !== 1'b1 && n < 20);
    if (wbRsp.ack !== 1'b1) bad_count++;
    rd = wbRsp.dat;
    wbReq <= '0;
  endtask
  task automatic core(input logic en, input logic [5:0] v);
    @(posedge sys_clk) {enterReq, leaveReq, enterVec} <= {en, !en, v};
    @(posedge sys_clk) {enterReq, leaveReq} <= 2'b00;
    @(posedge sys_clk) #1;
  endtask
  task automatic st(input logic [5:0] a, input logic r, input logic [5:0] i, input logic v);
    `CHK("act", a, actV)
    `CHK("ret", r, retB)
    `CHK("irq", i, irqI)
    `CHK("irqv", v, irqV)
  endtask
  task automatic t_nest;
    core(1, 6'h0f);
    st(6'h0f, 1, 0, 0);
    core(1, 6'h3b);
    st(6'h3b, 0, 6'h2b, 1);
    wb(0, ess_pkg::ADDR_STATE, 0);
    `CHK("state", 32'h3b, rd)
    core(0, 0);
    st(6'h0f, 1, 0, 0);
    core(0, 0);
    st(0, 1, 0, 0);
  endtask
  task automatic t_fault;
    core(1, 6'h03);
    core(1, 6'h10);
    st(6'h10, 1, 0, 1);
  endtask
  task automatic t_pend;
    @(posedge sys_clk) pendM <= 64'h1_0000_4000;
    prio[8*14 +: 8] <= 8'h40;
    prio[8*32 +: 8] <= 8'h20;
    core(0, 0);
    `CHK("pend", 6'h20, pendV)
    wb(1, ess_pkg::ADDR_PRIO, 32'h20);
    core(0, 0);
    `CHK("pbase", 6'h00, pendV)
    wb(1, ess_pkg::ADDR_PRIO, 32'h100);
    pendM <= 64'h1_0000_4004;
    core(0, 0);
    `CHK("pfault", 6'h02, pendV)
    wb(0, 4'hc, 0);
    `CHK("unmap", 32'h0, rd)
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #20000 bad_count++;
    complete_run;
  end
  initial begin
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_nest;
    t_fault;
    t_pend;
    complete_run;
  end
endmodule
